// File: lem_link_model.sv
// far-end serializer model: drives symbol, error and lock events
`default_nettype none

module lem_link_model (
  // clock
  input  wire logic i_clock,
  // link events
  output logic      o_sym_strobe,
  output logic      o_code_err,
  output logic      o_det_err,
  output logic      o_corr_err,
  output logic      o_prbs_err,
  output logic      o_video_lock_acq
);
  timeunit 1ns;
  timeprecision 1ps;

  // kind: 0 det, 1 corr, 2 prbs, 3 bad symbol, 4 lock, 5 good symbol
  logic [5:0] ev_q = 6'h00;

  assign o_det_err        = ev_q[0];
  assign o_corr_err       = ev_q[1];
  assign o_prbs_err       = ev_q[2];
  assign o_code_err       = ev_q[3];
  assign o_sym_strobe     = ev_q[3] | ev_q[5];
  assign o_video_lock_acq = ev_q[4];

  // one-cycle pulses, one idle cycle between them
  task automatic send(input int kind, input int n);
    repeat (n) begin
      @(posedge i_clock);
      ev_q <= 6'(1 << kind);
      @(posedge i_clock);
      ev_q <= 6'h00;
    end
  endtask
endmodule : lem_link_model

`default_nettype wire

// File: lem_pkg.sv
// constants and types for the link error monitor
`default_nettype none

package lem_pkg;

  // ****************************************
  // data widths
  // ****************************************
  localparam int unsigned CNT_W       = 8;
  localparam logic [7:0]  CNT_MAX     = 8'hFF;
  localparam logic [7:0]  CNT_ZERO    = 8'h00;
  localparam logic [7:0]  CNT_ONE     = 8'h01;

  // ****************************************
  // register indexes (byte address = 4 * index)
  // ****************************************
  localparam logic [7:0]  IDX_CFG      = 8'h08;
  localparam logic [7:0]  IDX_DET      = 8'h10;
  localparam logic [7:0]  IDX_CORR     = 8'h12;
  localparam logic [7:0]  IDX_PRBS     = 8'h13;
  localparam logic [7:0]  IDX_THR_DET  = 8'h20;
  localparam logic [7:0]  IDX_THR_CORR = 8'h21;
  localparam logic [7:0]  IDX_STAT     = 8'h30;
  localparam logic [7:0]  IDX_MASK     = 8'h31;
  localparam logic [7:0]  IDX_STATE    = 8'h32;

  // ****************************************
  // fields and reset values
  // ****************************************
  localparam int unsigned CFG_PRBS_BIT = 0;
  localparam int unsigned CFG_AUTO_BIT = 2;
  localparam logic [7:0]  CFG_WMASK    = 8'h05;
  localparam logic [7:0]  CFG_RESET    = 8'h00;
  localparam logic [7:0]  THR_RESET    = 8'h00;
  localparam int unsigned IRQ_W        = 3;
  localparam int unsigned IRQ_FLAG     = 0;
  localparam int unsigned IRQ_DROP     = 1;
  localparam int unsigned IRQ_LOCK     = 2;
  localparam logic [2:0]  IRQ_RESET    = 3'h0;

  // ****************************************
  // timing
  // ****************************************
  localparam logic [4:0]  WIN_LEN      = 5'h10;
  localparam logic [4:0]  BAD_LIMIT    = 5'(WIN_LEN >> 2);
  localparam int unsigned CLK_NS       = 50;
  localparam int unsigned AUTO_CLR_NS  = 1000;
  localparam logic [4:0]  AUTO_CLR_CYC = 5'(AUTO_CLR_NS / CLK_NS);

  // ****************************************
  // bus and states
  // ****************************************
  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;

  typedef enum logic {
    LEM_HUNT   = 1'b0,
    LEM_LOCKED = 1'b1
  } lem_lock_t;

endpackage : lem_pkg

`default_nettype wire

// File: lem_top.sv
// link error monitor: error counters, lock watch, error flag and AHB-Lite registers
//
// The implementer's own choice: the AHB-Lite register port.
`default_nettype none

module lem_top
  import lem_pkg::*;
(
  // clock and reset
  input  wire logic              i_clock,
  input  wire logic              i_rst_n,
  // ahb-lite slave
  input  wire logic              i_hsel,
  input  wire logic [31:0]       i_haddr,
  input  wire logic [1:0]        i_htrans,
  input  wire logic              i_hwrite,
  input  wire logic [2:0]        i_hsize,
  input  wire logic [31:0]       i_hwdata,
  input  wire logic              i_hready,
  output logic                   o_hreadyout,
  output logic [31:0]            o_hrdata,
  output logic                   o_hresp,
  // link events from the decoder
  input  wire logic              i_sym_strobe,
  input  wire logic              i_code_err,
  input  wire logic              i_det_err,
  input  wire logic              i_corr_err,
  input  wire logic              i_prbs_err,
  input  wire logic              i_video_lock_acq,
  // status outputs
  output logic                   o_video_lock,
  output logic                   o_relock_req,
  output logic                   o_err_n_o,
  output logic                   o_err_n_oe,
  output logic                   o_irq
);

  import lem_pkg::*;

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v, input logic inc);
    sat_inc = (inc && v != CNT_MAX) ? CNT_W'(v + CNT_ONE) : v;
  endfunction

  function automatic logic [CNT_W-1:0] cnt_next(input logic [CNT_W-1:0] v, input logic inc,
                                                input logic clr);
    // a new error in the clearing cycle survives
    cnt_next = clr ? (inc ? CNT_ONE : CNT_ZERO) : sat_inc(v, inc);
  endfunction

  // ****************************************
  // state
  // ****************************************
  lem_lock_t          lock_q, lock_d;
  logic [4:0]         win_q, win_d, bad_q, bad_d;
  logic [7:0]         det_q, det_d, corr_q, corr_d, prbs_cnt_q, prbs_cnt_d;
  logic               flag_q, flag_d;
  logic [4:0]         tmr_q, tmr_d;
  logic [7:0]         cfg_q, cfg_d, thr_det_q, thr_det_d, thr_corr_q, thr_corr_d;
  logic [IRQ_W-1:0]   stat_q, stat_d, mask_q, mask_d;
  logic               irq_q, irq_d;
  logic               dph_wr_q, dph_wr_d;
  logic [7:0]         dph_idx_q, dph_idx_d;
  logic [31:0]        hrdata_q, hrdata_d;

  logic               prbs_on, auto_en, count_on, drop, lock_acq;
  logic               accept, in_map, rd_det, rd_corr, rd_prbs, auto_on, auto_fire;
  logic               clr_all, any_clr, inc_det, inc_corr, inc_prbs, inc_any, exceed;
  logic [7:0]         a_idx;

  assign prbs_on  = cfg_q[CFG_PRBS_BIT];
  assign auto_en  = cfg_q[CFG_AUTO_BIT];

  // ****************************************
  // ahb-lite address phase decode
  // ****************************************
  assign accept  = i_hsel && i_hready && i_htrans[1];
  assign in_map  = (i_haddr[31:10] == 22'h0);
  assign a_idx   = i_haddr[9:2];
  assign rd_det  = accept && !i_hwrite && in_map && a_idx == IDX_DET;
  assign rd_corr = accept && !i_hwrite && in_map && a_idx == IDX_CORR;
  assign rd_prbs = accept && !i_hwrite && in_map && a_idx == IDX_PRBS;

  always_comb begin
    hrdata_d  = 32'h0;
    dph_wr_d  = accept && i_hwrite && in_map;
    dph_idx_d = a_idx;
    if (accept && !i_hwrite && in_map) begin
      unique case (a_idx)
        IDX_CFG:      hrdata_d = {24'h0, cfg_q};
        IDX_DET:      hrdata_d = {24'h0, det_q};
        IDX_CORR:     hrdata_d = {24'h0, corr_q};
        IDX_PRBS:     hrdata_d = {24'h0, prbs_cnt_q};
        IDX_THR_DET:  hrdata_d = {24'h0, thr_det_q};
        IDX_THR_CORR: hrdata_d = {24'h0, thr_corr_q};
        IDX_STAT:     hrdata_d = {29'h0, stat_q};
        IDX_MASK:     hrdata_d = {29'h0, mask_q};
        IDX_STATE:    hrdata_d = {29'h0, prbs_on, flag_q, lock_q == LEM_LOCKED};
        default:      hrdata_d = 32'h0;
      endcase
    end
  end

  // ****************************************
  // lock watch and error rate
  // ****************************************
  assign lock_acq = (lock_q == LEM_HUNT) && i_video_lock_acq;
  assign drop     = (lock_q == LEM_LOCKED) && i_sym_strobe && i_code_err && (5'(bad_q + 5'h1) >= BAD_LIMIT);

  always_comb begin
    lock_d = lock_q;
    win_d  = win_q;
    bad_d  = bad_q;
    unique case (lock_q)
      LEM_HUNT: begin
        win_d = 5'h0;
        bad_d = 5'h0;
        if (i_video_lock_acq) begin
          lock_d = LEM_LOCKED;
        end
      end
      LEM_LOCKED: begin
        if (drop) begin
          lock_d = LEM_HUNT;
        end else if (i_sym_strobe) begin
          if (5'(win_q + 5'h1) == WIN_LEN) begin
            win_d = 5'h0;
            bad_d = 5'h0;
          end else begin
            win_d = 5'(win_q + 5'h1);
            bad_d = 5'(bad_q + {4'h0, i_code_err});
          end
        end
      end
    endcase
  end

  // ****************************************
  // counters and error flag
  // ****************************************
  // detected and corrected counting frozen while hunting
  assign count_on  = (lock_q == LEM_LOCKED) && !prbs_on;
  assign inc_det   = count_on && i_det_err;
  assign inc_corr  = count_on && i_corr_err;
  assign inc_prbs  = prbs_on && i_prbs_err;
  assign inc_any   = inc_det || inc_corr || inc_prbs;
  // no automatic clear in PRBS test
  assign auto_on   = auto_en && !prbs_on && flag_q;
  assign auto_fire = auto_on && (tmr_q == 5'(AUTO_CLR_CYC - 5'h1));
  assign clr_all   = lock_acq || auto_fire;
  assign any_clr   = clr_all || rd_det || rd_corr || rd_prbs;

  always_comb begin
    if (prbs_on) begin
      det_d  = CNT_ZERO;
      corr_d = CNT_ZERO;
    end else begin
      det_d  = cnt_next(det_q, inc_det, clr_all || rd_det);
      corr_d = cnt_next(corr_q, inc_corr, clr_all || rd_corr);
    end
    prbs_cnt_d = cnt_next(prbs_cnt_q, inc_prbs, rd_prbs);
    exceed = prbs_on ? (prbs_cnt_d != CNT_ZERO) : ((det_d > thr_det_q) || (corr_d > thr_corr_q));
    // release on clear unless a new error lands and exceed is set
    flag_d = (any_clr ? 1'b0 : (flag_q || exceed)) || (exceed && inc_any);
    tmr_d  = (auto_on && !auto_fire) ? 5'(tmr_q + 5'h1) : 5'h0;
  end

  // ****************************************
  // register writes and interrupt
  // ****************************************
  always_comb begin
    cfg_d      = cfg_q;
    thr_det_d  = thr_det_q;
    thr_corr_d = thr_corr_q;
    mask_d     = mask_q;
    stat_d     = stat_q;
    if (dph_wr_q) begin
      unique case (dph_idx_q)
        IDX_CFG:      cfg_d = i_hwdata[7:0] & CFG_WMASK;
        IDX_THR_DET:  thr_det_d = i_hwdata[7:0];
        IDX_THR_CORR: thr_corr_d = i_hwdata[7:0];
        IDX_MASK:     mask_d = i_hwdata[IRQ_W-1:0];
        IDX_STAT:     stat_d = stat_q & ~i_hwdata[IRQ_W-1:0];
        default:      cfg_d = cfg_q;
      endcase
    end
    stat_d[IRQ_FLAG] = stat_d[IRQ_FLAG] || (flag_d && !flag_q);
    stat_d[IRQ_DROP] = stat_d[IRQ_DROP] || drop;
    stat_d[IRQ_LOCK] = stat_d[IRQ_LOCK] || lock_acq;
    irq_d = |(stat_d & mask_d);
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      lock_q     <= LEM_HUNT;
      win_q      <= 5'h0;
      bad_q      <= 5'h0;
      det_q      <= CNT_ZERO;
      corr_q     <= CNT_ZERO;
      prbs_cnt_q <= CNT_ZERO;
      flag_q     <= 1'b0;
      tmr_q      <= 5'h0;
      cfg_q      <= CFG_RESET;
      thr_det_q  <= THR_RESET;
      thr_corr_q <= THR_RESET;
      stat_q     <= IRQ_RESET;
      mask_q     <= IRQ_RESET;
      irq_q      <= 1'b0;
      dph_wr_q   <= 1'b0;
      dph_idx_q  <= 8'h00;
      hrdata_q   <= 32'h0;
    end else begin
      lock_q     <= lock_d;
      win_q      <= win_d;
      bad_q      <= bad_d;
      det_q      <= det_d;
      corr_q     <= corr_d;
      prbs_cnt_q <= prbs_cnt_d;
      flag_q     <= flag_d;
      tmr_q      <= tmr_d;
      cfg_q      <= cfg_d;
      thr_det_q  <= thr_det_d;
      thr_corr_q <= thr_corr_d;
      stat_q     <= stat_d;
      mask_q     <= mask_d;
      irq_q      <= irq_d;
      dph_wr_q   <= dph_wr_d;
      dph_idx_q  <= dph_idx_d;
      hrdata_q   <= hrdata_d;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign o_hreadyout  = 1'b1;
  assign o_hresp      = 1'b0;
  assign o_hrdata     = hrdata_q;
  assign o_video_lock = (lock_q == LEM_LOCKED);
  assign o_relock_req = (lock_q == LEM_HUNT);
  assign o_err_n_o    = 1'b0;
  assign o_err_n_oe   = flag_q;
  assign o_irq        = irq_q;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);

  a_det_counts: assert property (
    inc_det && !clr_all && !rd_det && !prbs_on && det_q != CNT_MAX |=> det_q == 8'($past(det_q) + 8'h01))
    else $error("detected count missed an error");
  a_drop_freeze: assert property (
    drop |=> !o_video_lock && o_relock_req ##1
    (det_q == $past(det_q) || $past(rd_det) || $past(prbs_on) || $past(clr_all)))
    else $error("lock not dropped or counting not frozen");
  a_lock_clears: assert property (
    lock_acq && !prbs_on |=> det_q == 8'h00 && corr_q == 8'h00 && !o_err_n_oe)
    else $error("counters or flag not cleared on video lock");
  a_prbs_hold: assert property (
    prbs_on |=> det_q == 8'h00 && corr_q == 8'h00)
    else $error("link counters not held at zero in PRBS test");
  a_flag_thresh: assert property (
    !prbs_on && !any_clr && (det_d > thr_det_q || corr_d > thr_corr_q) |=> o_err_n_oe)
    else $error("flag not asserted over threshold");
  a_flag_prbs: assert property (
    prbs_on && !any_clr && prbs_cnt_d != 8'h00 |=> o_err_n_oe)
    else $error("flag not asserted on PRBS error");
  a_flag_release: assert property (
    any_clr && !inc_any |=> !o_err_n_oe)
    else $error("flag not released on clear");
  a_read_clear: assert property (
    rd_corr && !inc_corr && !prbs_on |=> corr_q == 8'h00)
    else $error("corrected count not cleared by read");
  a_auto_delay: assert property (
    auto_fire |-> $past(o_err_n_oe, 19) && $past(o_err_n_oe, 10))
    else $error("automatic clear fired early");
  a_auto_fires: assert property (
    auto_fire && !inc_any |=> !o_err_n_oe && det_q == 8'h00)
    else $error("automatic clear did not clear");
  a_auto_prbs: assert property (
    prbs_on && o_err_n_oe && !rd_det && !rd_corr && !rd_prbs && !lock_acq |=> o_err_n_oe)
    else $error("automatic clear acted in PRBS test");
  a_sat_stay: assert property (
    det_q == 8'hFF && !clr_all && !rd_det && !prbs_on |=> det_q == 8'hFF)
    else $error("detected count wrapped");

  c_lock_drop: cover property (o_video_lock ##1 drop ##1 o_relock_req);
  c_auto_clear: cover property ($rose(o_err_n_oe) ##[19:21] auto_fire);
  c_prbs_flag: cover property (prbs_on && inc_prbs ##1 o_err_n_oe);
  c_read_clear: cover property (o_err_n_oe && rd_det ##1 !o_err_n_oe);

endmodule : lem_top

`default_nettype wire

// File: link_error_monitor_tb.sv
// self-checking bench for the link error monitor
`default_nettype none

module link_error_monitor_tb;
  import lem_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************
  // signals
  // ****************************************
  logic        i_clock = 1'b0;
  logic        i_rst_n = 1'b0;
  logic        hsel    = 1'b0;
  logic [31:0] haddr   = 32'h0;
  logic [1:0]  htrans  = 2'h0;
  logic        hwrite  = 1'b0;
  logic [31:0] hwdata  = 32'h0;
  wire logic   hready;
  wire logic [31:0] hrdata;
  wire logic   hresp, strobe, code, det, corr, prbs, lock_acq;
  wire logic   video_lock, relock, err_o, err_oe, irq;
  int          num_errors = 0;
  int          n_checks   = 0;
  int          cycles     = 0;
  logic [31:0] rd;

  always #25 i_clock = ~i_clock;

  lem_link_model i_link (.i_clock(i_clock), .o_sym_strobe(strobe), .o_code_err(code), .o_det_err(det),
    .o_corr_err(corr), .o_prbs_err(prbs), .o_video_lock_acq(lock_acq));

  lem_top i_dut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
    .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hready), .o_hreadyout(hready),
    .o_hrdata(hrdata), .o_hresp(hresp), .i_sym_strobe(strobe), .i_code_err(code), .i_det_err(det),
    .i_corr_err(corr), .i_prbs_err(prbs), .i_video_lock_acq(lock_acq), .o_video_lock(video_lock),
    .o_relock_req(relock), .o_err_n_o(err_o), .o_err_n_oe(err_oe), .o_irq(irq));

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic bus(input logic [7:0] idx, input logic wr, input logic [31:0] wd, output logic [31:0] q);
    @(posedge i_clock);
    hsel   <= 1'b1;
    haddr  <= 32'({idx, 2'b00});
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    do @(posedge i_clock); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge i_clock); while (hready !== 1'b1);
    q = hrdata;
    hsel <= 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp);
    bus(idx, 1'b0, 32'h0, rd);
    chk(rd, exp);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset;
    rdchk(IDX_CFG, 32'h0);
    chk(err_oe, 1'b0);
    chk(err_o, 1'b0);
    chk(hresp, 1'b0);
    chk(video_lock, 1'b0);
    $display("reset values done");
  endtask

  task automatic t_counts;
    i_link.send(4, 1);
    settle(2);
    chk(video_lock, 1'b1);
    bus(IDX_THR_CORR, 1'b1, 32'h2, rd);
    rdchk(IDX_THR_CORR, 32'h2);
    i_link.send(0, 3);
    i_link.send(1, 2);
    settle(2);
    chk(err_oe, 1'b1);
    rdchk(IDX_DET, 32'h3);
    settle(1);
    chk(err_oe, 1'b0);
    rdchk(IDX_DET, 32'h0);
    i_link.send(1, 1);
    settle(2);
    chk(err_oe, 1'b1);
    rdchk(IDX_CORR, 32'h3);
    i_link.send(0, 300);
    rdchk(IDX_DET, 32'hFF);
    $display("counting done");
  endtask

  task automatic t_auto;
    bus(IDX_CFG, 1'b1, 32'h4, rd);
    i_link.send(0, 1);
    // flag stands for the whole auto clear delay, then drops
    settle(AUTO_CLR_NS / CLK_NS - 1);
    chk(err_oe, 1'b1);
    settle(2);
    chk(err_oe, 1'b0);
    rdchk(IDX_DET, 32'h0);
    $display("auto clear done");
  endtask

  task automatic t_prbs;
    bus(IDX_CFG, 1'b1, 32'h5, rd);
    i_link.send(0, 2);
    i_link.send(2, 2);
    chk(err_oe, 1'b1);
    settle(30);
    chk(err_oe, 1'b1);
    rdchk(IDX_DET, 32'h0);
    rdchk(IDX_PRBS, 32'h2);
    settle(1);
    chk(err_oe, 1'b0);
    bus(IDX_CFG, 1'b1, 32'h0, rd);
    $display("prbs test done");
  endtask

  task automatic t_lock;
    i_link.send(5, 4);
    chk(video_lock, 1'b1);
    i_link.send(3, 4);
    settle(2);
    chk(video_lock, 1'b0);
    chk(relock, 1'b1);
    i_link.send(0, 2);
    rdchk(IDX_DET, 32'h0);
    i_link.send(4, 1);
    settle(2);
    chk(video_lock, 1'b1);
    // count two errors, then lose lock with the flag up
    i_link.send(0, 2);
    i_link.send(3, 4);
    settle(2);
    chk(video_lock, 1'b0);
    chk(err_oe, 1'b1);
    rdchk(IDX_STATE, 32'h2);
    i_link.send(4, 1);
    settle(2);
    chk(err_oe, 1'b0);
    rdchk(IDX_DET, 32'h0);
    $display("lock drop done");
  endtask

  task automatic t_irq;
    bus(IDX_STAT, 1'b1, 32'h7, rd);
    bus(IDX_MASK, 1'b1, 32'h1, rd);
    i_link.send(0, 1);
    settle(3);
    chk(irq, 1'b1);
    rdchk(IDX_DET, 32'h1);
    bus(IDX_STAT, 1'b1, 32'h1, rd);
    settle(2);
    chk(irq, 1'b0);
    rdchk(8'hFF, 32'h0);
    $display("interrupt done");
  endtask

  // ****************************************
  // run control
  // ****************************************
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  always @(posedge i_clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      summarize();
    end
  end

  initial begin
    repeat (3) @(posedge i_clock);
    i_rst_n <= 1'b1;
    t_reset();
    t_counts();
    t_auto();
    t_prbs();
    t_lock();
    t_irq();
    summarize();
  end
endmodule : link_error_monitor_tb

`default_nettype wire
